// File: inc/usf_pkg.sv
// Package with register offsets, field positions and reset values of the serial-port status block.
package usf_pkg;
  localparam logic [7:0] USF_OFS_STA = 8'h00;
  localparam logic [7:0] USF_OFS_STAH = 8'h04;
  localparam logic [7:0] USF_OFS_CFG = 8'h08;
  localparam logic [7:0] USF_OFS_TXD = 8'h0c;
  localparam logic [7:0] USF_OFS_RXD = 8'h10;
  localparam logic [7:0] USF_OFS_P1 = 8'h14;
  localparam logic [7:0] USF_OFS_P2 = 8'h18;
  // Status register low byte; the enable for each flag sits eight bits higher.
  localparam int USF_STA_SHE = 7;
  localparam int USF_STA_PARITY_OR_ADDRESS_FLAG = 6;
  localparam int USF_STA_ABD = 5;
  localparam int USF_STA_CHK = 4;
  localparam int USF_STA_FRAMING_ERR_FLAG = 3;
  localparam int USF_STA_BRK = 2;
  localparam int USF_STA_OVF = 1;
  localparam int USF_STA_COL = 0;
  localparam logic [7:0] USF_STICKY_MASK = 8'h37;
  // Buffer status register.
  localparam int USF_STAH_TXSEL = 12;
  localparam int USF_STAH_RXSEL = 8;
  localparam int USF_STAH_TX_WRITE_ERROR = 7;
  localparam int USF_STAH_STOP_DETECT_MODE = 6;
  localparam int USF_STAH_TXE = 5;
  localparam int USF_STAH_TXF = 4;
  localparam int USF_STAH_IDLE = 3;
  localparam int USF_STAH_XON = 2;
  localparam int USF_STAH_RXE = 1;
  localparam int USF_STAH_RXF = 0;
  // Configuration register.
  localparam int USF_CFG_FLO = 0;
  localparam int USF_CFG_INV = 2;
  localparam int USF_CFG_MODE = 4;
  localparam int USF_CFG_TXEN = 8;
  localparam int USF_CFG_RXEN = 9;
  localparam int USF_CFG_STOP_BIT_COUNT_SELECT = 10;
  localparam logic [1:0] USF_FLO_XON = 2'h1;
  localparam logic [1:0] USF_FLO_HW = 2'h2;
  localparam logic [1:0] USF_STOP_BIT_COUNT_SELECT_TWO = 2'h2;
  localparam logic [3:0] USF_MODE_PODD = 4'h2;
  localparam logic [3:0] USF_MODE_PEVEN = 4'h3;
  localparam logic [3:0] USF_MODE_ADDR = 4'h4;
  localparam logic [3:0] USF_MODE_LINS = 4'hb;
  localparam logic [3:0] USF_MODE_LINM = 4'hc;
  localparam logic USF_SHE_RST = 1'b1;
  localparam logic USF_TXPIN_RST = 1'b1;
  localparam logic USF_IDLE_RST = 1'b1;
endpackage

// File: core/usf_status_flags.sv
// Status, interrupt-enable, buffer-threshold and error-flag logic of a serial port, with an APB slave.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module usf_status_flags
  import usf_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_shift_level,
  output logic tx_pin,
  input wire logic tx_pop_req,
  output logic [7:0] tx_word,
  output logic tx_word_valid,
  input wire logic tx_stop_mid,
  input wire logic tx_stop_end,
  input wire logic rx_push,
  input wire logic [7:0] rx_data,
  input wire logic rx_stop_bad,
  input wire logic rx_stop1_mid,
  input wire logic rx_stop2_mid,
  input wire logic rx_stop_end,
  input wire logic rx_receiving,
  input wire logic parity_err_evt,
  input wire logic address_evt,
  input wire logic autobaud_rollover_evt,
  input wire logic checksum_err_evt,
  input wire logic rx_break_evt,
  input wire logic echo_valid,
  input wire logic [7:0] echo_tx_word,
  input wire logic [7:0] echo_rx_word,
  input wire logic xon_evt,
  input wire logic xoff_evt,
  input wire logic param_one_taken,
  output logic [8:0] param_one,
  output logic [8:0] param_two,
  output logic param_one_full,
  output logic flow_xon_mode,
  output logic flow_hw_mode,
  output logic tx_irq,
  output logic receive_irq,
  output logic uart_irq
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [31:0] prdata_reg, rd_mux;
  logic pready_reg, pslverr_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] sticky_reg, sticky_set, sticky_clr;
  logic shifter_empty_reg, parity_or_address_flag_reg, tx_write_error_reg, xon_reg, idle_reg;
  logic stop_detect_mode_reg;
  logic [2:0] tx_irq_threshold_reg, rx_irq_threshold_reg;
  logic [1:0] flow_ctrl_select_reg, stop_bit_count_select_reg;
  logic [3:0] protocol_mode_select_reg;
  logic tx_polarity_invert_reg, transmit_enable_bit_reg, receive_enable_bit_reg;
  logic [8:0] param_one_reg, param_two_reg;
  logic param_one_full_reg;
  logic tx_pin_reg, tx_irq_reg, rx_irq_reg, uart_irq_reg;
  logic flow_xon_reg, flow_hw_reg;
  logic [7:0] tx_word_reg;
  logic tx_word_valid_reg;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [DEPTH-1:0] rx_framing_err_flag_mem;
  logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [AW:0] tx_cnt_reg, rx_cnt_reg;

  // Bus decode. Registers answer in the first access cycle; writes land at that edge.
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_reg;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire hit_sta = paddr == USF_OFS_STA;
  wire hit_stah = paddr == USF_OFS_STAH;
  wire hit_cfg = paddr == USF_OFS_CFG;
  wire hit_txd = paddr == USF_OFS_TXD;
  wire hit_rxd = paddr == USF_OFS_RXD;
  wire hit_p1 = paddr == USF_OFS_P1;
  wire hit_p2 = paddr == USF_OFS_P2;
  wire mapped = hit_sta | hit_stah | hit_cfg | hit_txd | hit_rxd | hit_p1 | hit_p2;
  wire wr_sta = wr_acc & hit_sta;
  wire wr_stah = wr_acc & hit_stah;
  wire wr_cfg = wr_acc & hit_cfg;
  wire wr_txd = wr_acc & hit_txd;
  wire wr_p1 = wr_acc & hit_p1;
  wire rd_rxd = rd_acc & hit_rxd;

  wire mode_lin_par = protocol_mode_select_reg == USF_MODE_PODD || protocol_mode_select_reg == USF_MODE_PEVEN ||
                      protocol_mode_select_reg == USF_MODE_LINS || protocol_mode_select_reg == USF_MODE_LINM;
  wire mode_addr = protocol_mode_select_reg == USF_MODE_ADDR;
  wire mode_plain = ~protocol_mode_select_reg[3];

  // Buffer state.
  wire tx_empty = tx_cnt_reg == '0;
  wire tx_full = tx_cnt_reg == FULL_CNT;
  wire rx_empty = rx_cnt_reg == '0;
  wire rx_full = rx_cnt_reg == FULL_CNT;
  wire tx_p2_zero = mode_lin_par & (param_two_reg == '0);
  wire tx_bad_write = wr_txd & (tx_full | tx_p2_zero);
  wire tx_push = wr_txd & ~tx_bad_write;
  wire tx_pop = tx_pop_req & ~tx_empty & transmit_enable_bit_reg;
  wire tx_flush = wr_stah & pwdata[USF_STAH_TXE] & ~transmit_enable_bit_reg;
  wire rx_flush = wr_stah & pwdata[USF_STAH_RXE] & ~receive_enable_bit_reg;
  wire rx_overflow = rx_push & rx_full;
  wire rx_take = rx_push & ~rx_full & receive_enable_bit_reg;
  wire rx_pop = rd_rxd & ~rx_empty;
  wire framing_err_flag_top = ~rx_empty & rx_framing_err_flag_mem[rx_rp_reg];
  wire p1_bad_write = wr_p1 & mode_addr & param_one_full_reg;

  // Flag sources.
  wire parity_or_address_flag_set = (mode_lin_par & parity_err_evt) | (mode_addr & address_evt);
  wire collision = echo_valid & (echo_tx_word != echo_rx_word);
  always_comb begin
    sticky_set = '0;
    sticky_set[USF_STA_ABD] = autobaud_rollover_evt;
    sticky_set[USF_STA_CHK] = checksum_err_evt;
    sticky_set[USF_STA_BRK] = rx_break_evt;
    sticky_set[USF_STA_OVF] = rx_overflow;
    sticky_set[USF_STA_COL] = collision;
    sticky_clr = wr_sta ? ~pwdata[7:0] : 8'h00;
  end
  wire [7:0] sticky_next = ((sticky_reg & ~sticky_clr) | sticky_set) & USF_STICKY_MASK;
  wire tx_write_error_next = (tx_write_error_reg & ~(wr_stah & ~pwdata[USF_STAH_TX_WRITE_ERROR])) | tx_bad_write | p1_bad_write;

  wire [7:0] sta_flags = {shifter_empty_reg, parity_or_address_flag_reg, sticky_reg[5:4], framing_err_flag_top, sticky_reg[2:0]};
  wire [15:0] sta_val = {irq_en_reg, sta_flags};
  wire [15:0] stah_val = {1'b0, tx_irq_threshold_reg, 1'b0, rx_irq_threshold_reg, tx_write_error_reg, stop_detect_mode_reg,
                          tx_empty, tx_full, idle_reg, xon_reg, rx_empty, rx_full};
  wire [15:0] cfg_val = {4'h0, stop_bit_count_select_reg, receive_enable_bit_reg, transmit_enable_bit_reg,
                         protocol_mode_select_reg, 1'b0, tx_polarity_invert_reg, flow_ctrl_select_reg};
  wire [7:0] rx_head = rx_empty ? 8'h00 : rx_mem[rx_rp_reg];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_sta) begin
      rd_mux[15:0] = sta_val;
    end else if (hit_stah) begin
      rd_mux[15:0] = stah_val;
    end else if (hit_cfg) begin
      rd_mux[15:0] = cfg_val;
    end else if (hit_rxd) begin
      rd_mux[7:0] = rx_head;
    end else if (hit_p1) begin
      rd_mux[8:0] = param_one_reg;
    end else if (hit_p2) begin
      rd_mux[8:0] = param_two_reg;
    end
  end

  // Watermarks and event timing.
  wire tx_wm = tx_cnt_reg <= (AW + 1)'(tx_irq_threshold_reg);
  wire rx_wm = rx_cnt_reg > (AW + 1)'(rx_irq_threshold_reg);
  wire rx_suppress = (parity_or_address_flag_reg & irq_en_reg[USF_STA_PARITY_OR_ADDRESS_FLAG]) | (framing_err_flag_top & irq_en_reg[USF_STA_FRAMING_ERR_FLAG]);
  wire rx_mid_sel = stop_bit_count_select_reg == USF_STOP_BIT_COUNT_SELECT_TWO ? rx_stop2_mid : rx_stop1_mid;
  wire rx_point = stop_detect_mode_reg ? rx_stop_end : rx_mid_sel;
  wire tx_point = stop_detect_mode_reg ? tx_stop_end : tx_stop_mid;
  wire [1:0] flo_eff = mode_plain ? flow_ctrl_select_reg : 2'h0;

  // APB answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software-written configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 8'h00;
      tx_irq_threshold_reg <= 3'h0;
      rx_irq_threshold_reg <= 3'h0;
      stop_detect_mode_reg <= 1'b0;
      flow_ctrl_select_reg <= 2'h0;
      tx_polarity_invert_reg <= 1'b0;
      protocol_mode_select_reg <= 4'h0;
      transmit_enable_bit_reg <= 1'b0;
      receive_enable_bit_reg <= 1'b0;
      stop_bit_count_select_reg <= 2'h0;
      param_two_reg <= 9'h000;
    end else begin
      if (wr_sta) begin
        irq_en_reg <= pwdata[15:8];
      end
      if (wr_stah) begin
        tx_irq_threshold_reg <= pwdata[USF_STAH_TXSEL +: 3];
        rx_irq_threshold_reg <= pwdata[USF_STAH_RXSEL +: 3];
        stop_detect_mode_reg <= pwdata[USF_STAH_STOP_DETECT_MODE];
      end
      if (wr_cfg) begin
        flow_ctrl_select_reg <= pwdata[USF_CFG_FLO +: 2];
        tx_polarity_invert_reg <= pwdata[USF_CFG_INV];
        protocol_mode_select_reg <= pwdata[USF_CFG_MODE +: 4];
        transmit_enable_bit_reg <= pwdata[USF_CFG_TXEN];
        receive_enable_bit_reg <= pwdata[USF_CFG_RXEN];
        stop_bit_count_select_reg <= pwdata[USF_CFG_STOP_BIT_COUNT_SELECT +: 2];
      end
      if (wr_acc & hit_p2) begin
        param_two_reg <= pwdata[8:0];
      end
    end
  end

  // Parameter one holding slot; a write while full is refused in address mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_one_reg <= 9'h000;
      param_one_full_reg <= 1'b0;
    end else begin
      if (wr_p1 & ~p1_bad_write) begin
        param_one_reg <= pwdata[8:0];
      end
      param_one_full_reg <= (wr_p1 & mode_addr) | (param_one_full_reg & ~param_one_taken);
    end
  end

  // Flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_reg <= 8'h00;
      tx_write_error_reg <= 1'b0;
      parity_or_address_flag_reg <= 1'b0;
      shifter_empty_reg <= USF_SHE_RST;
      xon_reg <= 1'b0;
      idle_reg <= USF_IDLE_RST;
    end else begin
      sticky_reg <= sticky_next;
      tx_write_error_reg <= tx_write_error_next;
      parity_or_address_flag_reg <= parity_or_address_flag_set | (parity_or_address_flag_reg & ~rx_pop);
      // A load restarts the shifter, so it wins over a stop point in the same cycle.
      shifter_empty_reg <= ~tx_pop & (tx_point | shifter_empty_reg);
      xon_reg <= (flo_eff == USF_FLO_XON) & (xon_evt | (xon_reg & ~xoff_evt));
      idle_reg <= ~rx_receiving;
    end
  end

  // Transmit buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
      tx_word_reg <= 8'h00;
      tx_word_valid_reg <= 1'b0;
    end else begin
      tx_word_valid_reg <= tx_pop;
      if (tx_pop) begin
        tx_word_reg <= tx_mem[tx_rp_reg];
      end
      if (tx_flush) begin
        tx_wp_reg <= '0;
        tx_rp_reg <= '0;
        tx_cnt_reg <= '0;
      end else begin
        if (tx_push) begin
          tx_wp_reg <= tx_wp_reg + 1'b1;
        end
        if (tx_pop) begin
          tx_rp_reg <= tx_rp_reg + 1'b1;
        end
        tx_cnt_reg <= tx_cnt_reg + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
      end
    end
  end

  // Receive buffer; the stop-bit error bit is stored beside each character.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (rx_flush) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_take) begin
        rx_wp_reg <= rx_wp_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 1'b1;
      end
      rx_cnt_reg <= rx_cnt_reg + (AW + 1)'(rx_take) - (AW + 1)'(rx_pop);
    end
  end

  // Storage has no reset; entries are only read after being written.
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge pclk) begin
      if (tx_push && tx_wp_reg == AW'(i)) begin
        tx_mem[i] <= pwdata[7:0];
      end
      if (rx_take && rx_wp_reg == AW'(i)) begin
        rx_mem[i] <= rx_data;
        rx_framing_err_flag_mem[i] <= rx_stop_bad;
      end
    end
  end

  // Outputs to the line, the flow logic and the interrupt controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_reg <= USF_TXPIN_RST;
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      uart_irq_reg <= 1'b0;
      flow_xon_reg <= 1'b0;
      flow_hw_reg <= 1'b0;
    end else begin
      tx_pin_reg <= tx_shift_level ^ tx_polarity_invert_reg;
      tx_irq_reg <= tx_wm;
      // Raised only at the stop point so the interrupt lines up with the character boundary.
      rx_irq_reg <= rx_wm & ~rx_suppress & (rx_point | rx_irq_reg);
      uart_irq_reg <= |(sta_flags & irq_en_reg);
      flow_xon_reg <= flo_eff == USF_FLO_XON;
      flow_hw_reg <= flo_eff == USF_FLO_HW;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_pin = tx_pin_reg;
  assign tx_word = tx_word_reg;
  assign tx_word_valid = tx_word_valid_reg;
  assign param_one = param_one_reg;
  assign param_two = param_two_reg;
  assign param_one_full = param_one_full_reg;
  assign flow_xon_mode = flow_xon_reg;
  assign flow_hw_mode = flow_hw_reg;
  assign tx_irq = tx_irq_reg;
  assign receive_irq = rx_irq_reg;
  assign uart_irq = uart_irq_reg;

  property p_tx_polarity;
    @(posedge pclk) disable iff (!presetn) tx_polarity_invert_reg |=> tx_pin_reg == !$past(tx_shift_level);
  endproperty
  a_tx_polarity: assert property (p_tx_polarity) else $error("tx pin not inverted");

  property p_flow_reserved;
    @(posedge pclk) disable iff (!presetn) protocol_mode_select_reg[3] |=> !flow_xon_reg && !flow_hw_reg;
  endproperty
  a_flow_reserved: assert property (p_flow_reserved) else $error("flow control active in extended mode");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) rx_overflow && wr_sta && !pwdata[USF_STA_OVF] |=> sticky_reg[USF_STA_OVF];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow set lost to clear");

  property p_sticky_hold;
    @(posedge pclk) disable iff (!presetn) sticky_reg[USF_STA_CHK] && !wr_sta |=> sticky_reg[USF_STA_CHK];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("checksum flag dropped without write");

  property p_collision;
    @(posedge pclk) disable iff (!presetn) collision |=> sticky_reg[USF_STA_COL];
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_tx_write_error_full;
    @(posedge pclk) disable iff (!presetn) wr_txd && tx_full && !tx_pop |=> tx_write_error_reg && $stable(tx_cnt_reg);
  endproperty
  a_tx_write_error_full: assert property (p_tx_write_error_full) else $error("write to full buffer not refused");

  property p_rx_suppress;
    @(posedge pclk) disable iff (!presetn) rx_suppress |=> !rx_irq_reg;
  endproperty
  a_rx_suppress: assert property (p_rx_suppress) else $error("receive watermark not suppressed");

  property p_tx_flush;
    @(posedge pclk) disable iff (!presetn) tx_flush |=> tx_cnt_reg == '0 ##1 tx_irq_reg;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("transmit flush failed");
endmodule
`default_nettype wire

// File: tb/usf_far_model.sv
// Far-side model: stands in for the line shifters that feed the status block.
`timescale 1ns/100ps
`default_nettype none
module usf_far_model (
  input wire logic pclk,
  input wire logic [7:0] tx_word,
  input wire logic tx_word_valid,
  output logic tx_pop_req,
  output logic tx_shift_level,
  output logic rx_push,
  output logic [7:0] rx_data,
  output logic rx_stop_bad,
  output logic rx_stop1_mid,
  output logic rx_receiving
);
  logic [7:0] last_word = 8'h00;
  initial begin
    tx_pop_req = 1'b0;
    tx_shift_level = 1'b1;
    rx_push = 1'b0;
    rx_data = 8'h00;
    rx_stop_bad = 1'b0;
    rx_stop1_mid = 1'b0;
    rx_receiving = 1'b0;
  end
  always @(posedge pclk) begin
    if (tx_word_valid === 1'b1) begin
      last_word <= tx_word;
    end
  end
  // The stop point comes a cycle after the push, as a real receiver finishes the character then.
  task automatic send_char(input logic [7:0] d, input logic bad);
    rx_receiving <= 1'b1;
    @(posedge pclk);
    rx_push <= 1'b1;
    rx_data <= d;
    rx_stop_bad <= bad;
    @(posedge pclk);
    rx_push <= 1'b0;
    rx_data <= ~d;
    rx_stop_bad <= ~bad;
    rx_stop1_mid <= 1'b1;
    @(posedge pclk);
    rx_stop1_mid <= 1'b0;
    rx_receiving <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic drive_level(input logic v);
    tx_shift_level <= v;
    repeat (2) @(posedge pclk);
  endtask
  task automatic pop_one();
    tx_pop_req <= 1'b1;
    @(posedge pclk);
    tx_pop_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the serial-port status block.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import usf_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ev = 8'h00;
  logic echo_valid = 1'b0;
  logic [7:0] echo_tx = 8'h00;
  logic [7:0] echo_rx = 8'h00;
  logic [31:0] prdata, rq;
  logic pready, pslverr, re, tx_pin, tx_pop_req, tx_word_valid, tx_shift_level, tx_irq, receive_irq, uart_irq;
  logic rx_push, rx_stop_bad, rx_stop1_mid, rx_receiving, flow_xon_mode, flow_hw_mode;
  logic [7:0] tx_word, rx_data;
  int fails = 0;
  int cmp_count = 0;
  always #50 pclk = ~pclk;
  usf_status_flags #(.DEPTH(8)) usf_status_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_shift_level(tx_shift_level), .tx_pin(tx_pin), .tx_pop_req(tx_pop_req), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .tx_stop_mid(ev[7]), .tx_stop_end(1'b0), .rx_push(rx_push), .rx_data(rx_data),
    .rx_stop_bad(rx_stop_bad), .rx_stop1_mid(rx_stop1_mid), .rx_stop2_mid(1'b0), .rx_stop_end(1'b0),
    .rx_receiving(rx_receiving), .parity_err_evt(ev[0]), .address_evt(ev[1]), .autobaud_rollover_evt(ev[2]),
    .checksum_err_evt(ev[3]), .rx_break_evt(ev[4]), .echo_valid(echo_valid), .echo_tx_word(echo_tx),
    .echo_rx_word(echo_rx), .xon_evt(ev[5]), .xoff_evt(ev[6]), .param_one_taken(1'b0), .param_one(),
    .param_two(), .param_one_full(), .flow_xon_mode(flow_xon_mode), .flow_hw_mode(flow_hw_mode),
    .tx_irq(tx_irq), .receive_irq(receive_irq), .uart_irq(uart_irq));
  usf_far_model far_i (.pclk(pclk), .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_pop_req(tx_pop_req),
    .tx_shift_level(tx_shift_level), .rx_push(rx_push), .rx_data(rx_data), .rx_stop_bad(rx_stop_bad),
    .rx_stop1_mid(rx_stop1_mid), .rx_receiving(rx_receiving));
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Reads pready at the rising edge before that edge's updates land, so it sees what the slave showed.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      end_sim();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rq & m);
  endtask
  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 8'h00;
    @(posedge pclk);
  endtask
  task automatic echo(input logic [7:0] t, input logic [7:0] r);
    echo_tx <= t;
    echo_rx <= r;
    echo_valid <= 1'b1;
    @(posedge pclk);
    echo_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    rdc(USF_OFS_STA, 32'hffff, 32'h0080);
    rdc(USF_OFS_STAH, 32'hffff, 32'h002a);
    chk(32'h1, {31'h0, tx_irq});
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'h1, {31'h0, re});
    chk(32'h0, rq);
    $display("reset test done");
  endtask
  task automatic t_sticky();
    wr(USF_OFS_STA, 32'h3400);
    pulse(8'h1c);
    rdc(USF_OFS_STA, 32'hffff, 32'h34b4);
    chk(32'h1, {31'h0, uart_irq});
    wr(USF_OFS_STA, 32'h3400);
    rdc(USF_OFS_STA, 32'hffff, 32'h3480);
    chk(32'h0, {31'h0, uart_irq});
    echo(8'h3c, 8'h3c);
    rdc(USF_OFS_STA, 32'h1, 32'h0);
    echo(8'h3c, 8'hc3);
    rdc(USF_OFS_STA, 32'h1, 32'h1);
    $display("sticky test done");
  endtask
  task automatic t_tx();
    for (int i = 0; i < 8; i++) wr(USF_OFS_TXD, 32'h10 + 32'(i));
    rdc(USF_OFS_STAH, 32'h30, 32'h10);
    chk(32'h0, {31'h0, tx_irq});
    wr(USF_OFS_TXD, 32'haa);
    rdc(USF_OFS_STAH, 32'h80, 32'h80);
    wr(USF_OFS_STAH, 32'h7000);
    @(posedge pclk);
    chk(32'h0, {31'h0, tx_irq});
    wr(USF_OFS_CFG, 32'h100);
    far_i.pop_one();
    chk(32'h10, {24'h0, far_i.last_word});
    chk(32'h1, {31'h0, tx_irq});
    rdc(USF_OFS_STA, 32'h80, 32'h00);
    pulse(8'h80);
    rdc(USF_OFS_STA, 32'h80, 32'h80);
    wr(USF_OFS_CFG, 32'h0);
    wr(USF_OFS_STAH, 32'h0020);
    rdc(USF_OFS_STAH, 32'h70b0, 32'h0020);
    $display("transmit test done");
  endtask
  task automatic t_rx();
    wr(USF_OFS_CFG, 32'h200);
    wr(USF_OFS_STAH, 32'h0100);
    wr(USF_OFS_STA, 32'h0800);
    far_i.send_char(8'h5a, 1'b1);
    far_i.send_char(8'h66, 1'b0);
    chk(32'h0, {31'h0, receive_irq});
    rdc(USF_OFS_STA, 32'h8, 32'h8);
    rdc(USF_OFS_RXD, 32'hff, 32'h5a);
    rdc(USF_OFS_STA, 32'h8, 32'h0);
    far_i.send_char(8'h77, 1'b0);
    chk(32'h1, {31'h0, receive_irq});
    for (int i = 0; i < 6; i++) far_i.send_char(8'h80 + 8'(i), 1'b0);
    rdc(USF_OFS_STAH, 32'h3, 32'h1);
    far_i.send_char(8'h99, 1'b0);
    rdc(USF_OFS_STA, 32'h2, 32'h2);
    wr(USF_OFS_CFG, 32'h0);
    wr(USF_OFS_STAH, 32'h0002);
    rdc(USF_OFS_STAH, 32'h3, 32'h2);
    $display("receive test done");
  endtask
  task automatic t_cfg();
    for (int f = 0; f < 4; f++) begin
      wr(USF_OFS_CFG, 32'h4 | 32'(f));
      @(posedge pclk);
      chk(32'h0, {31'h0, tx_pin});
      chk(32'(f == 1 ? 1 : f == 2 ? 2 : 0), {30'h0, flow_hw_mode, flow_xon_mode});
    end
    far_i.drive_level(1'b0);
    chk(32'h1, {31'h0, tx_pin});
    far_i.drive_level(1'b1);
    wr(USF_OFS_CFG, 32'h1);
    @(posedge pclk);
    chk(32'h1, {31'h0, tx_pin});
    pulse(8'h20);
    rdc(USF_OFS_STAH, 32'h4, 32'h4);
    pulse(8'h40);
    rdc(USF_OFS_STAH, 32'h4, 32'h0);
    wr(USF_OFS_CFG, 32'hc1);
    @(posedge pclk);
    chk(32'h0, {31'h0, flow_xon_mode});
    wr(USF_OFS_CFG, 32'h20);
    pulse(8'h01);
    rdc(USF_OFS_STA, 32'h40, 32'h40);
    wr(USF_OFS_TXD, 32'h55);
    rdc(USF_OFS_STAH, 32'ha0, 32'ha0);
    wr(USF_OFS_STAH, 32'h0);
    wr(USF_OFS_CFG, 32'h40);
    wr(USF_OFS_P1, 32'h11);
    wr(USF_OFS_P1, 32'h22);
    rdc(USF_OFS_STAH, 32'h80, 32'h80);
    rdc(USF_OFS_P1, 32'h1ff, 32'h11);
    $display("config test done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sticky();
    t_tx();
    t_rx();
    t_cfg();
    end_sim();
  end
endmodule
`default_nettype wire
